// file: reset_sources_and_startup_sequencer.sv
// reset source combiner and start-up sequencer with axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module reset_sources_and_startup_sequencer
  import reset_seq_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_COUNT = POWERUP_DELAY_TIMER_CYCLES,
  parameter int BOR_COUNT  = BOR_FILT_CYC,
  parameter int PIN_COUNT  = MASTER_CLEAR_N_FILT_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog monitors and pin, asynchronous
  input  wire logic        power_on_reset,
  input  wire logic        supply_low,
  input  wire logic        brownout_circuit_ready,
  input  wire logic        master_clear_n,
  input  wire logic        osc_startup_done,
  // core events, same clock
  input  wire logic        watchdog_timeout,
  input  wire logic        reset_insn,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  input  wire logic        prog_mode_exit,
  input  wire logic        sleep_req,
  input  wire logic        gpio_pullup_sw,
  // outputs
  output logic             device_reset,
  output logic             wake_stall,
  output logic             brownout_enable,
  output logic             pin_pullup_en,
  output logic             pin_gpio_in
);

  localparam int CNT_W = $clog2(POWERUP_DELAY_TIMER_COUNT + 1);
  localparam int BFW   = $clog2(BOR_COUNT + 1);
  localparam int PFW   = $clog2(PIN_COUNT + 1);
  localparam int SYNC_W = 5;
  localparam int SY_POR = 0;
  localparam int SY_LOW = 1;
  localparam int SY_RDY = 2;
  localparam int SY_PIN = 3;
  localparam int SY_OST = 4;

  //----------
  // state
  //----------
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    seq_e              seq;
    logic              hold;
    logic [CNT_W-1:0]  powerup_delay_timer_cnt;
    logic [BFW-1:0]    bor_cnt;
    logic [PFW-1:0]    pin_cnt;
    logic              pin_filt;
    logic              soft_en;
    logic [6:0]        cfg;
    logic              stk_ovf;
    logic              stk_unf;
    logic              pin_n;
    logic              insn_n;
    logic              por_n;
    logic              bor_n;
    logic              to_n;
    logic              pd_n;
    logic              gpio;
    logic              aw_got;
    logic [3:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } seq_s;

  seq_s state;
  seq_s next_state;

  logic [SYNC_W-1:0] raw_in;
  logic              pin_en;
  logic              pin_hold;
  logic [1:0]        mode;
  logic              bor_prot;
  logic              bor_trip;
  logic              powerup_delay_timer_done;
  logic              bor_ok;
  logic              ost_ok;
  logic              por_evt;
  logic              wr_fire;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_word;

  assign raw_in = {osc_startup_done, master_clear_n, brownout_circuit_ready,
                   supply_low, power_on_reset};

  //----------
  // derived conditions
  //----------
  // clear pin enable and filtered hold
  assign pin_en   = state.cfg[SC_PIN_EN] | state.cfg[SC_LVP]; // R13
  assign pin_hold = pin_en & ~state.pin_filt; // R14

  // brownout mode decode and protection
  assign mode = state.cfg[SC_MODE_HI:SC_MODE_LO]; // R5
  always_comb
  begin
    case (mode)
      BOR_ALWAYS_ON: brownout_enable = 1'b1; // R7
      BOR_NO_SLEEP:  brownout_enable = (state.seq != SEQ_SLEEP); // R8
      BOR_SOFTWARE:  brownout_enable = state.soft_en; // R9 R10 R11
      default:       brownout_enable = 1'b0;
    endcase
  end
  assign bor_prot = brownout_enable & state.sync2[SY_RDY]; // R10
  assign bor_trip = bor_prot & state.sync2[SY_LOW]
                    & (state.bor_cnt == BFW'(BOR_COUNT)); // R6

  // start-up gates
  assign powerup_delay_timer_done = state.cfg[SC_POWERUP_DELAY_TIMER_EN_N]
                     | (state.powerup_delay_timer_cnt == CNT_W'(POWERUP_DELAY_TIMER_COUNT)); // R1 R3
  assign bor_ok = ~((mode == BOR_ALWAYS_ON) | (mode == BOR_NO_SLEEP))
                  | (state.sync2[SY_RDY] & ~state.sync2[SY_LOW]); // R7 R8 R9
  assign ost_ok = ~state.cfg[SC_OST_REQ] | state.sync2[SY_OST];
  assign por_evt = state.sync2[SY_POR] | prog_mode_exit; // R20

  // bus decode
  assign wr_fire = state.aw_got & state.w_got & ~state.bvalid;
  // every aligned word of the map is a register
  assign wr_hit  = ~|state.aw_addr[1:0];
  assign rd_hit  = ~|s_axi_araddr[1:0];

  // read data mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_BROWNOUT_CONTROL:
      begin
        rd_word[BC_SOFT_EN] = state.soft_en; // R11
        rd_word[BC_READY]   = bor_prot; // R12
      end
      ADDR_POWER_CONTROL:
      begin
        rd_word[PC_STK_OVF] = state.stk_ovf;
        rd_word[PC_STK_UNF] = state.stk_unf;
        rd_word[PC_PIN_N]   = state.pin_n;
        rd_word[PC_INSN_N]  = state.insn_n;
        rd_word[PC_POR_N]   = state.por_n;
        rd_word[PC_BOR_N]   = state.bor_n;
      end
      ADDR_RESET_STATUS:
      begin
        rd_word[RS_PD_N]    = state.pd_n;
        rd_word[RS_TO_N]    = state.to_n;
        rd_word[RS_RUNNING] = ~state.hold;
      end
      ADDR_STARTUP_CONFIG: rd_word[6:0] = state.cfg;
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;

    // input synchronisers
    next_state.sync1 = raw_in;
    next_state.sync2 = state.sync1;

    // clear pin glitch filter
    if (state.sync2[SY_PIN] == state.pin_filt)
      next_state.pin_cnt = '0;
    else if (state.pin_cnt == PFW'(PIN_COUNT))
    begin
      next_state.pin_filt = state.sync2[SY_PIN]; // R15
      next_state.pin_cnt  = '0;
    end
    else
      next_state.pin_cnt = state.pin_cnt + PFW'(1); // R15
    next_state.gpio = pin_en ? 1'b0 : state.sync2[SY_PIN]; // R16

    // brownout low-supply duration filter
    if (bor_prot & state.sync2[SY_LOW])
    begin
      if (state.bor_cnt != BFW'(BOR_COUNT))
        next_state.bor_cnt = state.bor_cnt + BFW'(1); // R6
    end
    else
      next_state.bor_cnt = '0; // R6

    // axi write channel capture
    if (s_axi_awvalid & s_axi_awready)
    begin
      next_state.aw_got  = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready)
    begin
      next_state.w_got   = 1'b1;
      next_state.w_data  = s_axi_wdata;
      next_state.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (state.w_lane0)
      begin
        case (state.aw_addr)
          ADDR_BROWNOUT_CONTROL:
            next_state.soft_en = state.w_data[BC_SOFT_EN]; // R11
          ADDR_POWER_CONTROL:
          begin
            next_state.stk_ovf = state.w_data[PC_STK_OVF];
            next_state.stk_unf = state.w_data[PC_STK_UNF];
            next_state.pin_n   = state.w_data[PC_PIN_N]; // R23
            next_state.insn_n  = state.w_data[PC_INSN_N];
            next_state.por_n   = state.w_data[PC_POR_N];
            next_state.bor_n   = state.w_data[PC_BOR_N];
          end
          ADDR_STARTUP_CONFIG: next_state.cfg = state.w_data[6:0];
          default:             next_state.cfg = state.cfg;
        endcase
      end
    end
    else if (state.bvalid & s_axi_bready)
      next_state.bvalid = 1'b0;

    // axi read channel
    if (s_axi_arvalid & s_axi_arready)
    begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd_word;
      next_state.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (state.rvalid & s_axi_rready)
      next_state.rvalid = 1'b0;

    // start-up sequence; hardware flag updates follow writes so they win
    case (state.seq)
      SEQ_POWER:
      begin
        next_state.powerup_delay_timer_cnt = '0;
        if (~state.sync2[SY_POR] & ~state.sync2[SY_LOW])
          next_state.seq = SEQ_TIMERS; // R4
      end
      SEQ_TIMERS:
      begin
        if (~powerup_delay_timer_done)
          next_state.powerup_delay_timer_cnt = state.powerup_delay_timer_cnt + CNT_W'(1); // R1 R22
        if (powerup_delay_timer_done & bor_ok & ost_ok)
          next_state.seq = SEQ_PIN; // R2 R21
      end
      SEQ_PIN:
      begin
        if (~pin_hold)
          next_state.seq = SEQ_RUN; // R21 R22
      end
      SEQ_RUN:
      begin
        if (pin_hold)
        begin
          next_state.pin_n = 1'b0; // R23
          next_state.seq   = SEQ_PIN; // R14
        end
        else if (watchdog_timeout)
        begin
          next_state.to_n = 1'b0; // R17
          next_state.seq  = SEQ_SOFT; // R17
        end
        else if (reset_insn)
        begin
          next_state.insn_n = 1'b0; // R18
          next_state.seq    = SEQ_SOFT; // R18
        end
        else if (state.cfg[SC_STK_EN] & (stack_overflow | stack_underflow))
        begin
          if (stack_overflow)
            next_state.stk_ovf = 1'b1; // R19
          if (stack_underflow)
            next_state.stk_unf = 1'b1; // R19
          next_state.seq = SEQ_SOFT; // R19
        end
        else if (sleep_req)
        begin
          next_state.pd_n = 1'b0;
          next_state.seq  = SEQ_SLEEP;
        end
      end
      SEQ_SLEEP:
      begin
        if (pin_hold)
        begin
          next_state.pin_n = 1'b0; // R23
          next_state.to_n  = 1'b1;
          next_state.seq   = SEQ_PIN; // R14
        end
        else if (watchdog_timeout | ~sleep_req)
        begin
          if (watchdog_timeout)
            next_state.to_n = 1'b0; // R17
          next_state.seq = (mode == BOR_NO_SLEEP) ? SEQ_WAKE : SEQ_RUN; // R7 R8
        end
      end
      SEQ_WAKE:
      begin
        if (pin_hold)
        begin
          next_state.pin_n = 1'b0; // R23
          next_state.seq   = SEQ_PIN;
        end
        else if (state.sync2[SY_RDY])
          next_state.seq = SEQ_RUN; // R8
      end
      SEQ_SOFT: next_state.seq = SEQ_PIN;
      default:  next_state.seq = SEQ_POWER;
    endcase

    // power-on, programming exit and brownout restart the whole sequence
    if (por_evt | bor_trip)
    begin
      next_state.seq      = SEQ_POWER; // R20
      next_state.powerup_delay_timer_cnt = '0;
      next_state.bor_n    = 1'b0;
      if (por_evt)
        next_state.por_n = 1'b0;
      next_state.pin_n   = 1'b1;
      next_state.insn_n  = 1'b1;
      next_state.stk_ovf = 1'b0;
      next_state.stk_unf = 1'b0;
      next_state.to_n    = 1'b1;
      next_state.pd_n    = 1'b1;
    end

    next_state.hold = ~((next_state.seq == SEQ_RUN)
                        | (next_state.seq == SEQ_SLEEP)
                        | (next_state.seq == SEQ_WAKE)); // R2
  end

  //----------
  // registers
  //----------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state          <= '0;
      state.sync1    <= 5'h08;
      state.sync2    <= 5'h08;
      state.seq      <= SEQ_POWER;
      state.hold     <= 1'b1;
      state.pin_filt <= 1'b1;
      state.soft_en  <= SOFT_BOR_EN_RESET;
      state.cfg      <= STARTUP_CONFIG_RESET;
      state.pin_n    <= 1'b1;
      state.insn_n   <= 1'b1;
      state.to_n     <= 1'b1;
      state.pd_n     <= 1'b1;
    end
    else
      state <= next_state;
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  // raw power-on detector asserts at once, release is synchronous
  reset_release_bridge u_bridge
  (
    .aclk      (aclk),
    .reset_req (power_on_reset | state.hold | ~aresetn),
    .reset_out (device_reset)
  ); // R24

  assign wake_stall    = (state.seq == SEQ_WAKE); // R8
  assign pin_pullup_en = pin_en | gpio_pullup_sw; // R16
  assign pin_gpio_in   = state.gpio;

  assign s_axi_awready = ~state.aw_got & ~state.bvalid;
  assign s_axi_wready  = ~state.w_got & ~state.bvalid;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = ~state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

endmodule // reset_sources_and_startup_sequencer
`default_nettype wire

// file: reset_seq_pkg.sv
// constants, register map and state type of the reset and start-up sequencer
//------------------------------------------------------------------------------
// Operation
// R1 - power-up timer times out after 64 ms
// R2 - reset held while power-up timer runs
// R3 - timer enable bit low enables, high bypasses
// R4 - timer starts after power-on and brownout release
// R5 - two-bit field selects one of four brownout modes
// R6 - brownout trips only after filtered low supply
// R7 - mode 11 waits ready, protects in sleep
// R8 - mode 10 off in sleep, wake waits ready
// R9 - mode 01 soft enable, start-up never waits
// R10 - mode 01 protects once ready, sleep ignored
// R11 - soft enable stays writable, inert outside 01
// R12 - ready status bit 0, bits 6..1 zero
// R13 - clear pin enabled by enable or low-voltage bit
// R14 - enabled clear pin held low holds reset
// R15 - clear pin filter drops short low pulses
// R16 - disabled clear pin is input, pull-up software
// R17 - watchdog timeout resets, updates timeout flags
// R18 - reset instruction resets, clears its flag
// R19 - enabled stack faults reset and set flags
// R20 - programming-mode exit acts like power-on
// R21 - run after timers expire and pin released
// R22 - timers ignore clear pin; run on release
// R23 - clear pin reset clears flag; firmware sets it
// R24 - reset asserts asynchronously, releases synchronously
//------------------------------------------------------------------------------
package reset_seq_pkg;

  // clock and timing
  localparam int CLK_HZ        = 20_000_000;
  localparam int POWERUP_DELAY_TIMER_TIME_MS  = 64;
  localparam int POWERUP_DELAY_TIMER_CYCLES   = POWERUP_DELAY_TIMER_TIME_MS * (CLK_HZ / 1000);
  localparam int BOR_FILT_NS   = 1000;
  localparam int BOR_FILT_CYC  = (BOR_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MASTER_CLEAR_N_FILT_NS  = 200;
  localparam int MASTER_CLEAR_N_FILT_CYC = (MASTER_CLEAR_N_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // register byte addresses
  localparam logic [3:0] ADDR_BROWNOUT_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_POWER_CONTROL    = 4'h4;
  localparam logic [3:0] ADDR_RESET_STATUS     = 4'h8;
  localparam logic [3:0] ADDR_STARTUP_CONFIG   = 4'hC;

  // brownout_control fields
  localparam int BC_SOFT_EN = 7;
  localparam int BC_READY   = 0;
  // power_control_reg fields
  localparam int PC_STK_OVF = 7;
  localparam int PC_STK_UNF = 6;
  localparam int PC_PIN_N   = 3;
  localparam int PC_INSN_N  = 2;
  localparam int PC_POR_N   = 1;
  localparam int PC_BOR_N   = 0;
  // reset_status fields
  localparam int RS_PD_N    = 0;
  localparam int RS_TO_N    = 1;
  localparam int RS_RUNNING = 2;
  // startup_config fields
  localparam int SC_POWERUP_DELAY_TIMER_EN_N = 0;
  localparam int SC_MODE_LO   = 1;
  localparam int SC_MODE_HI   = 2;
  localparam int SC_PIN_EN    = 3;
  localparam int SC_LVP       = 4;
  localparam int SC_STK_EN    = 5;
  localparam int SC_OST_REQ   = 6;

  localparam logic [6:0] STARTUP_CONFIG_RESET = 7'h0E;
  localparam logic       SOFT_BOR_EN_RESET    = 1'b1;

  // brownout modes
  localparam logic [1:0] BOR_ALWAYS_ON = 2'h3;
  localparam logic [1:0] BOR_NO_SLEEP  = 2'h2;
  localparam logic [1:0] BOR_SOFTWARE  = 2'h1;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // start-up sequence
  typedef enum logic [2:0] {
    SEQ_POWER,
    SEQ_TIMERS,
    SEQ_PIN,
    SEQ_RUN,
    SEQ_SLEEP,
    SEQ_WAKE,
    SEQ_SOFT
  } seq_e;

endpackage

// file: reset_release_bridge.sv
// reset bridge: asynchronous assertion, two-stage synchronous release
`timescale 1ns/100ps
`default_nettype none
module reset_release_bridge
  import reset_seq_pkg::*;
(
  input  wire logic aclk,
  input  wire logic reset_req,
  output logic      reset_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } bridge_s;

  bridge_s state;
  bridge_s next_state;

  // shift zeros in once the request is gone
  always_comb
  begin
    next_state.stage1 = 1'b0;
    next_state.stage2 = state.stage1;
  end

  // request sets both stages at once, release takes two edges
  always_ff @(posedge aclk or posedge reset_req)
  begin
    if (reset_req)
      state <= 2'h3; // R24
    else
      state <= next_state; // R24
  end

  assign reset_out = state.stage2;

endmodule // reset_release_bridge
`default_nettype wire

// file: reset_seq_chk.sv
// port assertions for the reset and start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_seq_chk
  import reset_seq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        power_on_reset,
  input wire logic        master_clear_n,
  input wire logic        watchdog_timeout,
  input wire logic        reset_insn,
  input wire logic        sleep_req,
  input wire logic        gpio_pullup_sw,
  input wire logic        device_reset,
  input wire logic        wake_stall,
  input wire logic        pin_pullup_en,
  input wire logic        pin_gpio_in
);
  //----------
  // checks
  //----------
  logic [3:0] rd_addr;
  logic       clr_on;
  // address of the read under way
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  end
  // clear function on while software pull-up is off
  assign clr_on = pin_pullup_en && !gpio_pullup_sw;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_ready_zero: assert property (s_axi_rvalid && rd_addr == 4'h0 |->
    s_axi_rdata[6:1] == 6'h00) else $error("brownout bits not zero");
  a_por_hold: assert property (power_on_reset |-> device_reset)
    else $error("reset low during power-on");
  a_sync_release: assert property ($fell(device_reset) |->
    !power_on_reset && !$past(power_on_reset)) else $error("bad release");
  a_pin_hold: assert property ((clr_on && !master_clear_n)[*8] |=>
    device_reset) else $error("clear pin low but running");
  a_gpio_mask: assert property (clr_on[*2] |-> !pin_gpio_in)
    else $error("gpio input seen while clear enabled");
  a_wdog_reset: assert property ((!sleep_req)[*4] ##0 (watchdog_timeout
    && !device_reset && !wake_stall) |-> ##[1:6] device_reset)
    else $error("watchdog timeout did not reset");
  a_insn_reset: assert property ((!sleep_req)[*4] ##0 (reset_insn
    && !device_reset && !wake_stall) |-> ##[1:6] device_reset)
    else $error("reset instruction did not reset");
endmodule // reset_seq_chk
bind reset_sources_and_startup_sequencer reset_seq_chk chk (.*);
`default_nettype wire

// file: analog_partner.sv
// supply monitors and clear-pin driver facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module analog_partner
  import reset_seq_pkg::*;
#(
  parameter int RDY_DLY = 6
)
(
  input  wire logic aclk,
  input  wire logic por_cmd,
  input  wire logic low_cmd,
  input  wire logic pin_low,
  input  wire logic brownout_enable,
  input  wire logic pin_pullup_en,
  output logic      power_on_reset,
  output logic      supply_low,
  output logic      brownout_circuit_ready,
  output logic      master_clear_n,
  output logic      osc_startup_done
);
  //----------
  // model
  //----------
  logic [3:0] warm = 4'h0;
  logic       flip = 1'h0;
  // circuit warms up after enable; floating pin wanders
  always @(posedge aclk)
  begin
    if (brownout_enable !== 1'h1)
      warm <= 4'h0;
    else if (warm != 4'(RDY_DLY))
      warm <= warm + 4'h1;
    flip <= !flip;
  end
  assign brownout_circuit_ready = (warm == 4'(RDY_DLY));
  assign power_on_reset = por_cmd;
  assign supply_low = low_cmd;
  assign osc_startup_done = 1'h1;
  // pin may be held low through the start-up timers
  assign master_clear_n = pin_low ? 1'h0 : (pin_pullup_en | flip);
endmodule // analog_partner
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the reset and start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import reset_seq_pkg::*;
;
  //----------
  // bench
  //----------
  localparam int PW = 50;
  typedef struct {logic [3:0] a; logic w; logic [7:0] d, e;
    logic [1:0] r;} row_s;
  logic        aclk = 1'h0, aresetn, por_cmd, low_cmd, pin_low, s, u;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dat;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, power_on_reset, supply_low;
  logic        brownout_circuit_ready, master_clear_n, osc_startup_done;
  logic        watchdog_timeout, reset_insn, stack_overflow;
  logic        stack_underflow, prog_mode_exit, sleep_req, gpio_pullup_sw;
  logic        device_reset, wake_stall, brownout_enable, pin_pullup_en;
  logic        pin_gpio_in;
  int          failures, n_tests, cyc, n;
  row_s rows [11] = '{'{4'h0,1'h0,8'h00,8'h81,RESP_OKAY},
    '{4'h4,1'h0,8'h00,8'h0C,RESP_OKAY}, '{4'h8,1'h0,8'h00,8'h07,RESP_OKAY},
    '{4'hC,1'h0,8'h00,8'h0E,RESP_OKAY}, '{4'h2,1'h0,8'h00,8'h00,RESP_SLVERR},
    '{4'h2,1'h1,8'hFF,8'h00,RESP_SLVERR}, '{4'h0,1'h1,8'h7E,8'h00,RESP_OKAY},
    '{4'h0,1'h0,8'h00,8'h01,RESP_OKAY}, '{4'h4,1'h1,8'h0F,8'h00,RESP_OKAY},
    '{4'h4,1'h0,8'h00,8'h0F,RESP_OKAY}, '{4'h0,1'h1,8'h80,8'h00,RESP_OKAY}};
  logic [7:0] modes [6] = '{8'hAE, 8'hAC, 8'hAA, 8'h2A, 8'h2E, 8'hA8};
  reset_sources_and_startup_sequencer #(.POWERUP_DELAY_TIMER_COUNT(PW), .BOR_COUNT(3),
    .PIN_COUNT(2)) DUT (.*);
  analog_partner partner (.*);
  // clock and hang guard
  always #25 aclk = !aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
    end while (!tb);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'h0;
    end while (!tr);
    s_axi_rready <= 1'h0;
  endtask
  // one-cycle core event: 0 prog exit, 1 watchdog, 2 insn, 3 stack
  task automatic hit(input int k);
    @(posedge aclk);
    {stack_overflow, reset_insn, watchdog_timeout, prog_mode_exit} <=
      4'(1 << k);
    @(posedge aclk);
    {stack_overflow, reset_insn, watchdog_timeout, prog_mode_exit} <= 4'h0;
  endtask
  task automatic saw(output logic v);
    v = 1'h0;
    repeat (12)
    begin
      @(negedge aclk);
      if (device_reset === 1'h1)
        v = 1'h1;
    end
  endtask
  task automatic run_wait(output int c);
    c = 0;
    while (device_reset !== 1'h0 && c < 400)
    begin
      @(negedge aclk);
      c = c + 1;
    end
  endtask
  task automatic pin_hold(input int c);
    @(posedge aclk);
    pin_low <= 1'h1;
    repeat (c) @(posedge aclk);
    pin_low <= 1'h0;
    saw(u);
  endtask
  // main sequence
  initial
  begin
    {aresetn, low_cmd, pin_low, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, watchdog_timeout} = '0;
    {reset_insn, stack_overflow, stack_underflow, prog_mode_exit} = '0;
    {sleep_req, gpio_pullup_sw, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, failures, n_tests, cyc} = '0;
    s_axi_wstrb = 4'hF;
    por_cmd = 1'h1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    por_cmd <= 1'h0;
    run_wait(n);
    chk("startup", 1'h1, n >= PW && n <= PW + 16);
    foreach (rows[i])
    begin
      if (rows[i].w)
        axw(rows[i].a, {24'h0, rows[i].d}, rsp);
      else
        axr(rows[i].a, dat, rsp);
      chk("resp", rows[i].r, rsp);
      if (!rows[i].w)
        chk("rdata", {24'h0, rows[i].e}, dat);
    end
    hit(1);
    saw(s);
    chk("wdog rst", 1'h1, s);
    axr(4'h8, dat, rsp);
    chk("status", 32'h05, dat);
    hit(2);
    saw(s);
    chk("insn rst", 1'h1, s);
    hit(3);
    saw(s);
    chk("stk off", 1'h0, s);
    axw(4'hC, 32'h2E, rsp);
    hit(3);
    saw(s);
    axr(4'h4, dat, rsp);
    chk("stk rst", 1'h1, s);
    chk("flags", 32'h8B, dat);
    pin_hold(1);
    chk("glitch", 1'h0, u);
    pin_hold(20);
    chk("pin rst", 1'h1, u);
    run_wait(n);
    axr(4'h4, dat, rsp);
    chk("pin flag", 32'h83, dat);
    axw(4'hC, 32'h26, rsp);
    pin_hold(20);
    chk("pin off", 1'h0, u);
    gpio_pullup_sw <= 1'h1;
    repeat (5) @(posedge aclk);
    chk("gpio", 1'h1, pin_gpio_in & pin_pullup_en);
    gpio_pullup_sw <= 1'h0;
    axw(4'hC, 32'h36, rsp);
    pin_hold(20);
    chk("lvp pin", 1'h1, u);
    run_wait(n);
    foreach (modes[i])
    begin
      axw(4'h0, {24'h0, modes[i][7], 7'h0}, rsp);
      axw(4'hC, {25'h0, modes[i][6:0] & 7'h2E | 7'h08}, rsp);
      repeat (8) @(posedge aclk);
      chk("bor en", !(i inside {3, 5}), brownout_enable);
    end
    low_cmd <= 1'h1;
    saw(s);
    low_cmd <= 1'h0;
    chk("bor off", 1'h0, s);
    axw(4'hC, 32'h2E, rsp);
    repeat (10) @(posedge aclk);
    low_cmd <= 1'h1;
    repeat (2) @(posedge aclk);
    low_cmd <= 1'h0;
    saw(s);
    chk("dip", 1'h0, s);
    low_cmd <= 1'h1;
    saw(s);
    low_cmd <= 1'h0;
    run_wait(n);
    chk("bor rst", 1'h1, s && n >= PW && n <= PW + 16);
    axr(4'h4, dat, rsp);
    chk("bor flag", 32'h02, dat & 32'h03);
    hit(0);
    pin_hold(PW + 30);
    chk("held", 1'h1, u);
    run_wait(n);
    chk("pin go", 1'h1, n <= 10);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
